// file: rtl/sbc_commutator.sv
/*
 Three-phase sine-wave PWM commutator with hall sensing, lead angle,
 dead time, protection blocks, tach and reverse detection, plus a small
 register port with interrupt. Assumes pins are asynchronous and that
 speed and advance codes come from an external converter.
*/
// Decided for this implementation: the register offsets and strobed register access.
// Behaviour
// - A triangular carrier of 252 clock cycles is the reference for all duty comparisons; the bootstrap duty compares the rising carrier count car_r instead.
// - Each phase duty follows a sine-shaped profile locked to rotor position.
// - Commutation leads the sensed position by 0 to 58 degrees in 32 steps.
// - Dead time is 3.8 us with the select low and 2.6 us with it high.
// - All-high or all-low position inputs block every drive output.
// - Direction select low gives forward and high gives reverse rotation.
// - Halt low stops operation and forces all drive outputs inactive.
// - Polarity select low makes the outputs active low, high makes them active high.
// - Overcurrent blocks the outputs until the first carrier cycle boundary after it clears.
// - The tach output gives three pulses per electrical turn.
// - Rotation opposite to the commanded direction raises the backspin flag.
// - A speed command at or below the low level drives only the lower switches at 8% duty.
// - Speed commands at or above full scale are saturated to full scale.
`timescale 1ns/1ps
module sbc_commutator
   import sbc_pkg::*;
#(
   parameter int unsigned PERIOD_W = 20
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Motor pins
   input wire logic i_pos_sense_a,
   input wire logic i_pos_sense_b,
   input wire logic i_pos_sense_c,
   input wire logic i_dir_select,
   input wire logic i_halt_n,
   input wire logic i_drive_polarity,
   input wire logic i_deadband_sel,
   input wire logic i_overcurrent,
   input wire logic [sbc_pkg::SPEED_W-1:0] i_speed_command,
   input wire logic [sbc_pkg::ADV_W-1:0] i_phase_advance,
   // Register port
   input wire logic [sbc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [31:0] o_rd_data,
   output logic o_irq,
   // Turn-on outputs, upper U V W and lower X Y Z
   output logic o_drive_u,
   output logic o_drive_v,
   output logic o_drive_w,
   output logic o_drive_x,
   output logic o_drive_y,
   output logic o_drive_z,
   // Status pins
   output logic o_tach_pulse,
   output logic o_backspin_flag
);
   import sbc_pkg::*;

   function automatic logic [2:0] sector_of(input logic [2:0] h);
      unique case (h)
         3'b001: sector_of = 3'd0;
         3'b011: sector_of = 3'd1;
         3'b010: sector_of = 3'd2;
         3'b110: sector_of = 3'd3;
         3'b100: sector_of = 3'd4;
         3'b101: sector_of = 3'd5;
         default: sector_of = SECTOR_BAD;
      endcase
   endfunction

   function automatic logic [2:0] step_sector(input logic [2:0] s, input logic up);
      if (up)
         step_sector = (s == 3'd5) ? 3'd0 : s + 3'd1;
      else
         step_sector = (s == 3'd0) ? 3'd5 : s - 3'd1;
   endfunction

   function automatic logic [7:0] wrap_angle(input logic [9:0] v);
      logic [9:0] w;
      w = v;
      if (w >= 10'(ANGLE_STEPS))
         w = w - 10'(ANGLE_STEPS);
      if (w >= 10'(ANGLE_STEPS))
         w = w - 10'(ANGLE_STEPS);
      wrap_angle = w[7:0];
   endfunction

   // Parabolic half-wave per half turn, centred on half the carrier
   function automatic logic [6:0] sine_duty(input logic [7:0] ang, input logic [7:0] spd);
      logic [6:0] h;
      logic [11:0] par;
      logic [19:0] prod;
      logic [6:0] mag;
      h = (ang < ANGLE_HALF) ? ang[6:0] : 7'(ang - ANGLE_HALF);
      par = 12'(h) * (12'(ANGLE_HALF) - 12'(h));
      prod = 20'(par) * 20'(spd);
      mag = (prod[19:13] > DUTY_SWING) ? DUTY_SWING : prod[19:13];
      sine_duty = (ang < ANGLE_HALF) ? DUTY_MID + mag : DUTY_MID - mag;
   endfunction

   // Pin synchronisers
   logic [2:0] hall_s1, hall_s2;
   logic dir_s1, dir_s2, halt_s1, halt_s2, pol_s1, pol_s2;
   logic dsel_s1, dsel_s2, oc_s1, oc_s2;
   logic [SPEED_W-1:0] spd_s1, spd_s2;
   logic [ADV_W-1:0] adv_s1, adv_s2;

   always_ff @(posedge i_clock)
   begin
      hall_s1 <= {i_pos_sense_c, i_pos_sense_b, i_pos_sense_a};
      hall_s2 <= hall_s1;
      {dir_s1, halt_s1, pol_s1, dsel_s1, oc_s1} <=
         {i_dir_select, i_halt_n, i_drive_polarity, i_deadband_sel, i_overcurrent};
      {dir_s2, halt_s2, pol_s2, dsel_s2, oc_s2} <= {dir_s1, halt_s1, pol_s1, dsel_s1, oc_s1};
      spd_s1 <= i_speed_command;
      spd_s2 <= spd_s1;
      adv_s1 <= i_phase_advance;
      adv_s2 <= adv_s1;
   end

   logic run;
   assign run = i_rst_n && halt_s2;

   // Carrier
   logic [7:0] car_r;
   logic [7:0] tri_val;
   always_ff @(posedge i_clock)
   begin
      if (!run)
         car_r <= 8'h00;
      else
         car_r <= (car_r == CARRIER_LAST) ? 8'h00 : car_r + 8'h01;
   end
   assign tri_val = (car_r < CARRIER_HALF) ? car_r : CARRIER_LAST - car_r;

   // Rotor position tracking and interpolation within a sector
   logic [2:0] hall_sector;
   logic fault, change, fwd_step, rev_step;
   logic [2:0] sector_r;
   logic [PERIOD_W-1:0] period_r;
   logic [PERIOD_W-6:0] step_r, tick_r;
   logic [4:0] sub_r;
   logic fault_r, backspin_r, tach_r;

   assign hall_sector = sector_of(hall_s2);
   assign fault = (hall_sector == SECTOR_BAD);
   assign change = !fault && (hall_sector != sector_r);
   assign fwd_step = change && (hall_sector == step_sector(sector_r, 1'b1));
   assign rev_step = change && (hall_sector == step_sector(sector_r, 1'b0));

   always_ff @(posedge i_clock)
   begin
      if (!run)
      begin
         sector_r <= 3'd0;
         period_r <= '1;
         step_r <= '1;
         tick_r <= '0;
         sub_r <= 5'd0;
      end
      else if (change)
      begin
         sector_r <= hall_sector;
         step_r <= period_r[PERIOD_W-1:5];
         period_r <= '0;
         tick_r <= '0;
         sub_r <= 5'd0;
      end
      else
      begin
         if (period_r != '1)
            period_r <= period_r + 1'b1;
         if (tick_r >= step_r && sub_r != SUB_LAST)
         begin
            tick_r <= '0;
            sub_r <= sub_r + 5'd1;
         end
         else
            tick_r <= tick_r + 1'b1;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!run)
      begin
         fault_r <= 1'b0;
         backspin_r <= 1'b0;
         tach_r <= 1'b0;
      end
      else
      begin
         fault_r <= fault;
         tach_r <= ^hall_s2;
         if (fwd_step)
            backspin_r <= dir_s2;
         else if (rev_step)
            backspin_r <= !dir_s2;
      end
   end

   // Electrical angle with lead; reverse walks the angle downward
   logic [9:0] ang_raw;
   logic [7:0] ang_a;
   logic [6:0] duty [3];
   logic [SPEED_W-1:0] spd_sat;

   assign spd_sat = (spd_s2 >= SPEED_FULL) ? SPEED_FULL : spd_s2;
   always_comb
   begin
      if (dir_s2)
         ang_raw = 10'({sector_r, 5'd0}) + 10'(ANGLE_STEPS) + 10'(SUB_LAST)
                   - 10'(sub_r) - 10'(adv_s2);
      else
         ang_raw = 10'({sector_r, 5'd0}) + 10'(sub_r) + 10'(adv_s2);
   end
   assign ang_a = wrap_angle(ang_raw);
   assign duty[0] = sine_duty(ang_a, spd_sat);
   assign duty[1] = sine_duty(wrap_angle(10'(ang_a) + 10'(PHASE_B_OFS)), spd_sat);
   assign duty[2] = sine_duty(wrap_angle(10'(ang_a) + 10'(PHASE_C_OFS)), spd_sat);

   // Overcurrent block, released only at the carrier boundary
   logic oc_block_r;
   always_ff @(posedge i_clock)
   begin
      if (!run)
         oc_block_r <= 1'b0;
      else if (oc_s2)
         oc_block_r <= 1'b1;
      else if (car_r == 8'h00)
         oc_block_r <= 1'b0;
   end

   // Legs
   logic boot, leg_enable;
   logic [DEAD_W-1:0] dead_cycles;
   logic [2:0] up_req, lo_req, on_up, on_lo;

   assign boot = (spd_sat <= SPEED_LOW);
   assign leg_enable = !fault && !fault_r && !oc_block_r;
   assign dead_cycles = dsel_s2 ? DEAD_SHORT_CYC : DEAD_LONG_CYC;

   for (genvar i = 0; i < 3; i++)
   begin : g_leg
      assign up_req[i] = !boot && (tri_val < 8'(duty[i]));
      assign lo_req[i] = boot ? (car_r < BOOT_ON_CYC) : !up_req[i];
      sbc_deadband #(.CNT_W(DEAD_W)) u_leg
      (
         .i_clock(i_clock),
         .i_rst_n(run),
         .i_enable(leg_enable),
         .i_up_req(up_req[i]),
         .i_lo_req(lo_req[i]),
         .i_dead_cycles(dead_cycles),
         .o_up(on_up[i]),
         .o_lo(on_lo[i])
      );
   end

   // Pins, polarity applied last
   always_ff @(posedge i_clock)
   begin
      o_drive_u <= pol_s2 ? on_up[0] : !on_up[0];
      o_drive_v <= pol_s2 ? on_up[1] : !on_up[1];
      o_drive_w <= pol_s2 ? on_up[2] : !on_up[2];
      o_drive_x <= pol_s2 ? on_lo[0] : !on_lo[0];
      o_drive_y <= pol_s2 ? on_lo[1] : !on_lo[1];
      o_drive_z <= pol_s2 ? on_lo[2] : !on_lo[2];
      o_tach_pulse <= tach_r;
      o_backspin_flag <= backspin_r;
   end

   // Events, interrupt and register port
   logic [EV_W-1:0] status_r, enable_r, events, clr;
   logic irq_r;
   assign events[EV_OVERCUR] = oc_s2 && !oc_block_r && run;
   assign events[EV_PATTERN] = fault && !fault_r && run;
   assign events[EV_BACKSPIN] = run && !backspin_r && ((fwd_step && dir_s2) || (rev_step && !dir_s2));
   assign clr = (i_wr_en && i_addr == REG_CLEAR) ? i_wr_data[EV_W-1:0] : '0;

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         status_r <= '0;
         enable_r <= ENABLE_RST;
         irq_r <= 1'b0;
         o_rd_data <= 32'h0000_0000;
      end
      else
      begin
         status_r <= (status_r & ~clr) | events;
         if (i_wr_en && i_addr == REG_ENABLE)
            enable_r <= i_wr_data[EV_W-1:0];
         irq_r <= |(status_r & enable_r);
         if (!i_rd_en)
            o_rd_data <= 32'h0000_0000;
         else
            unique case (i_addr)
               REG_ENABLE: o_rd_data <= 32'(enable_r);
               REG_STATUS: o_rd_data <= 32'(status_r);
               REG_STATE: o_rd_data <= 32'({boot, oc_block_r, fault_r, backspin_r, sector_r});
               default: o_rd_data <= 32'h0000_0000;
            endcase
      end
   end
   assign o_irq = irq_r;

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_carrier_wrap: assert property (run && car_r == CARRIER_LAST |=> car_r == 8'h00)
      else $error("carrier did not wrap after 252 cycles");
   a_duty_range: assert property (duty[0] <= 7'(CARRIER_HALF - 8'h01))
      else $error("duty outside carrier span");
   a_pattern_block: assert property (fault |=> ##1 (on_up == 3'b000 && on_lo == 3'b000))
      else $error("drive on with illegal position pattern");
   a_halt_inactive: assert property (!halt_s2 |=> ##1
      (o_drive_u == !$past(pol_s2) && o_drive_z == !$past(pol_s2)))
      else $error("drive not inactive during halt");
   a_oc_hold: assert property ($fell(oc_block_r) && $past(run) |->
      $past(car_r) == 8'h00 && !$past(oc_s2))
      else $error("overcurrent block released early");
   a_oc_block: assert property (oc_s2 && run |=> ##1 (on_up == 3'b000 && on_lo == 3'b000))
      else $error("drive on during overcurrent");
   a_boot_lower: assert property (boot && run |=> on_up == 3'b000)
      else $error("upper switch on in bootstrap mode");
   a_backspin_set: assert property (fwd_step && dir_s2 && run |=> backspin_r)
      else $error("reverse rotation not flagged");
   a_tach_follow: assert property (run && $past(run) |-> tach_r == ^$past(hall_s2))
      else $error("tach does not follow sensor parity");
   a_irq_level: assert property ((|(status_r & enable_r)) |=> o_irq)
      else $error("interrupt not raised");
endmodule // sbc_commutator

// file: rtl/sbc_deadband.sv
/*
 One inverter leg: turns upper/lower demand into non-overlapping drive
 with a dead interval after every turn-off.
 Assumes demands and dead count come from the same clock domain.
*/
`timescale 1ns/1ps
module sbc_deadband
#(
   parameter int unsigned CNT_W = 9
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Demand
   input wire logic i_enable,
   input wire logic i_up_req,
   input wire logic i_lo_req,
   input wire logic [CNT_W-1:0] i_dead_cycles,
   // Drive, active high
   output logic o_up,
   output logic o_lo
);
   logic [CNT_W-1:0] cnt_r;
   // Switch that went off last may come back without a gap
   logic rearm_up_r;
   logic rearm_lo_r;

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_up <= 1'b0;
         o_lo <= 1'b0;
         cnt_r <= '1;
         rearm_up_r <= 1'b0;
         rearm_lo_r <= 1'b0;
      end
      else if (!i_enable)
      begin
         o_up <= 1'b0;
         o_lo <= 1'b0;
         cnt_r <= i_dead_cycles;
         rearm_up_r <= 1'b0;
         rearm_lo_r <= 1'b0;
      end
      else if (o_up || o_lo)
      begin
         if ({i_up_req, i_lo_req} != {o_up, o_lo})
         begin
            o_up <= 1'b0;
            o_lo <= 1'b0;
            cnt_r <= i_dead_cycles;
            rearm_up_r <= o_up;
            rearm_lo_r <= o_lo;
         end
      end
      else if (cnt_r != '0)
      begin
         cnt_r <= cnt_r - 1'b1;
         // Gap only guards the complement, so the same switch may return
         o_up <= rearm_up_r && i_up_req && !i_lo_req;
         o_lo <= rearm_lo_r && i_lo_req && !i_up_req;
      end
      else
      begin
         o_up <= i_up_req && !i_lo_req;
         o_lo <= i_lo_req;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_no_overlap: assert property (!(o_up && o_lo))
      else $error("both switches of one leg on");
   a_gap_after_up: assert property ($fell(o_up) |=> !o_lo [*8])
      else $error("lower turned on inside dead time");
   a_gap_after_lo: assert property ($fell(o_lo) |=> !o_up [*8])
      else $error("upper turned on inside dead time");
endmodule // sbc_deadband

// file: rtl/sbc_pkg.sv
/*
 Shared constants for the sine-wave PWM commutator: carrier, dead time,
 angle resolution, bootstrap mode and register map.
 Assumes a 100 MHz core clock.
*/
package sbc_pkg;
   // Core clock
   localparam int unsigned CLK_MHZ = 100;

   // Triangular carrier
   localparam int unsigned CARRIER_CYCLES = 252;
   localparam logic [7:0] CARRIER_LAST = 8'(CARRIER_CYCLES - 1);
   localparam logic [7:0] CARRIER_HALF = 8'(CARRIER_CYCLES / 2);
   localparam logic [6:0] DUTY_MID = 7'(CARRIER_CYCLES / 4);
   localparam logic [6:0] DUTY_SWING = 7'(CARRIER_CYCLES / 4 - 1);

   // Dead time, figures in ns, rounded up to whole cycles
   localparam int unsigned DEAD_W = 9;
   localparam int unsigned DEAD_LONG_NS = 3800;
   localparam int unsigned DEAD_SHORT_NS = 2600;
   localparam logic [DEAD_W-1:0] DEAD_LONG_CYC = DEAD_W'((DEAD_LONG_NS * CLK_MHZ + 999) / 1000);
   localparam logic [DEAD_W-1:0] DEAD_SHORT_CYC = DEAD_W'((DEAD_SHORT_NS * CLK_MHZ + 999) / 1000);

   // Electrical angle: 32 steps of 1.875 deg per 60 deg sector
   localparam int unsigned SUB_STEPS = 32;
   localparam logic [8:0] ANGLE_STEPS = 9'd192;
   localparam logic [7:0] ANGLE_HALF = 8'd96;
   localparam logic [7:0] PHASE_B_OFS = 8'd64;
   localparam logic [7:0] PHASE_C_OFS = 8'd128;
   localparam logic [4:0] SUB_LAST = 5'(SUB_STEPS - 1);
   localparam logic [2:0] SECTOR_BAD = 3'h7;

   // Speed command codes (8-bit converter, full scale = reference)
   localparam int unsigned SPEED_W = 8;
   localparam logic [SPEED_W-1:0] SPEED_FULL = 8'hff;
   localparam logic [SPEED_W-1:0] SPEED_LOW = 8'h0a;
   localparam int unsigned BOOT_PCT = 8;
   localparam logic [7:0] BOOT_ON_CYC = 8'(CARRIER_CYCLES * BOOT_PCT / 100);
   localparam int unsigned ADV_W = 5;

   // Register map
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_ENABLE = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_CLEAR = 4'h8;
   localparam logic [ADDR_W-1:0] REG_STATE = 4'hc;
   localparam int unsigned EV_W = 3;
   localparam int unsigned EV_OVERCUR = 0;
   localparam int unsigned EV_PATTERN = 1;
   localparam int unsigned EV_BACKSPIN = 2;
   localparam logic [EV_W-1:0] ENABLE_RST = 3'h0;
endpackage

// file: tb/sbc_motor_model.sv
/*
 Motor side model: hall sensor sequence and gate driver watch.
 Assumes the drive outputs settle between edges of the core clock.
*/
`timescale 1ns/1ps
module sbc_motor_model
(
   // Clock and sensor control
   input wire logic i_clock,
   input wire logic i_step,
   input wire logic i_rev,
   input wire logic i_fault,
   input wire logic [2:0] i_fault_code,
   // Drive watch
   input wire logic i_check,
   input wire logic i_pol,
   input wire logic i_dead_sel,
   input wire logic [2:0] i_up,
   input wire logic [2:0] i_lo,
   // Hall pins and tallies
   output logic o_sa,
   output logic o_sb,
   output logic o_sc,
   output int o_viol,
   output int o_up_on,
   output int o_lo_on
);
   logic [2:0] code_tab [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
   logic [2:0] up, lo, up_q, lo_q;
   int sec = 0;
   int dead;
   int gap_u [3] = '{default: 1000};
   int gap_l [3] = '{default: 1000};
   assign up = i_pol ? i_up : ~i_up;
   assign lo = i_pol ? i_lo : ~i_lo;
   assign dead = i_dead_sel ? 260 : 380;
   assign {o_sc, o_sb, o_sa} = i_fault ? i_fault_code : code_tab[sec];
   always @(posedge i_clock)
   begin
      if (i_step)
         sec <= i_rev ? (sec + 5) % 6 : (sec + 1) % 6;
      for (int p = 0; p < 3; p++)
      begin
         // Overlap, or a switch on too soon after its partner went off
         if (i_check && ((up[p] && lo[p]) || (up[p] && !up_q[p] && gap_l[p] < dead)
             || (lo[p] && !lo_q[p] && gap_u[p] < dead)))
            o_viol <= o_viol + 1;
         gap_u[p] <= up[p] ? 0 : gap_u[p] + 1;
         gap_l[p] <= lo[p] ? 0 : gap_l[p] + 1;
      end
      up_q <= up;
      lo_q <= lo;
      if (i_check && |up)
         o_up_on <= o_up_on + 1;
      if (i_check && lo[0])
         o_lo_on <= o_lo_on + 1;
   end
endmodule // sbc_motor_model

// file: tb/sine_pwm_bldc_commutator_tb.sv
/*
 Self-checking bench for the commutator: blocking rows, run, registers.
 Assumes the motor model file is compiled before it.
*/
`timescale 1ns/1ps
module sine_pwm_bldc_commutator_tb;
   import sbc_pkg::*;
   typedef struct packed {logic halt_n; logic pol; logic fault; logic [2:0] code; logic oc;
      logic [5:0] exp;} sbc_row_t;
   localparam sbc_row_t ROWS [6] = '{'{1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 6'h3f},
      '{1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 6'h00}, '{1'b1, 1'b1, 1'b1, 3'h0, 1'b0, 6'h00},
      '{1'b1, 1'b0, 1'b1, 3'h7, 1'b0, 6'h3f}, '{1'b1, 1'b1, 1'b0, 3'h0, 1'b1, 6'h00},
      '{1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 6'h3f}};
   logic clock = 0, rst_n = 0, halt_n = 0, dir = 0, pol = 1, dsel = 1, oc = 0;
   logic [7:0] speed = 8'h00;
   logic [4:0] adv = 5'h00;
   logic [3:0] addr = 4'h0;
   logic [31:0] wr_data = 32'h0, rd_data, rd;
   logic wr_en = 0, rd_en = 0, irq, tach, bs, sa, sb, sc, step = 0, backspin_flag = 0, fault = 0, chk = 0;
   logic [2:0] fault_code = 3'h0;
   logic [5:0] drv;
   int viol, up_on, lo_on, b, bl, errors = 0, checks = 0;
   always #5 clock = ~clock;
   sbc_commutator i_sbc_commutator (.i_clock(clock), .i_rst_n(rst_n), .i_pos_sense_a(sa),
      .i_pos_sense_b(sb), .i_pos_sense_c(sc), .i_dir_select(dir), .i_halt_n(halt_n),
      .i_drive_polarity(pol), .i_deadband_sel(dsel), .i_overcurrent(oc),
      .i_speed_command(speed), .i_phase_advance(adv), .i_addr(addr), .i_wr_data(wr_data),
      .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .o_irq(irq), .o_drive_u(drv[5]),
      .o_drive_v(drv[4]), .o_drive_w(drv[3]), .o_drive_x(drv[2]), .o_drive_y(drv[1]),
      .o_drive_z(drv[0]), .o_tach_pulse(tach), .o_backspin_flag(bs));
   sbc_motor_model i_sbc_motor_model (.i_clock(clock), .i_step(step), .i_rev(backspin_flag),
      .i_fault(fault), .i_fault_code(fault_code), .i_check(chk), .i_pol(pol),
      .i_dead_sel(dsel), .i_up(drv[5:3]), .i_lo(drv[2:0]), .o_sa(sa), .o_sb(sb), .o_sc(sc),
      .o_viol(viol), .o_up_on(up_on), .o_lo_on(lo_on));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(posedge clock);
      d = rd_data;
   endtask
   task automatic step_hall(input logic r);
      @(posedge clock);
      step <= 1'b1;
      backspin_flag <= r;
      @(posedge clock);
      step <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   task automatic restart();
      halt_n <= 1'b0;
      repeat (4) @(posedge clock);
      halt_n <= 1'b1;
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #800_000;
      errors++;
      end_of_test;
   end
   initial
   begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      reg_rd(REG_ENABLE, rd);
      check("enable_rst", rd, 32'(ENABLE_RST));
      reg_wr(4'h2, 32'hffff_ffff);
      reg_rd(4'h2, rd);
      check("unmapped", rd, 32'h0);
      reg_wr(REG_ENABLE, 32'h7);
      reg_rd(REG_ENABLE, rd);
      check("enable", rd, 32'h7);
      speed <= 8'hff;
      adv <= 5'h1f;
      // Running motor, both dead-time settings
      for (int d = 0; d < 2; d++)
      begin
         dsel <= d[0];
         dir <= 1'b0;
         restart();
         chk <= 1'b1;
         for (int s = 0; s < 8; s++)
         begin
            step_hall(1'b0);
            check("tach", 32'(tach), 32'(sa ^ sb ^ sc));
            check("backspin_fwd", 32'(bs), 32'h0);
            repeat (1500) @(posedge clock);
         end
         step_hall(1'b1);
         check("backspin_rev", 32'(bs), 32'h1);
         dir <= 1'b1;
         step_hall(1'b1);
         check("backspin_dir", 32'(bs), 32'h0);
         repeat (1500) @(posedge clock);
         chk <= 1'b0;
         check("overlap", viol, 0);
      end
      check("upper_active", 32'(up_on != 0), 32'h1);
      dir <= 1'b0;
      foreach (ROWS[i])
      begin
         pol <= ROWS[i].pol;
         restart();
         repeat (1200) @(posedge clock);
         halt_n <= ROWS[i].halt_n;
         fault <= ROWS[i].fault;
         fault_code <= ROWS[i].code;
         oc <= ROWS[i].oc;
         repeat (8) @(posedge clock);
         check("drives", 32'(drv), 32'(ROWS[i].exp));
         fault <= 1'b0;
         oc <= 1'b0;
      end
      halt_n <= 1'b1;
      reg_rd(REG_STATUS, rd);
      check("status", rd, 32'h7);
      check("irq_on", 32'(irq), 32'h1);
      reg_wr(REG_CLEAR, 32'h7);
      reg_rd(REG_STATUS, rd);
      check("status_clr", rd, 32'h0);
      check("irq_off", 32'(irq), 32'h0);
      reg_wr(REG_ENABLE, 32'h0);
      fault <= 1'b1;
      repeat (8) @(posedge clock);
      fault <= 1'b0;
      reg_rd(REG_STATUS, rd);
      check("status_mask", rd, 32'h2);
      check("irq_mask", 32'(irq), 32'h0);
      // Bootstrap at the low speed boundary
      pol <= 1'b1;
      speed <= 8'h0a;
      restart();
      chk <= 1'b1;
      repeat (1000) @(posedge clock);
      b = up_on;
      bl = lo_on;
      repeat (8 * CARRIER_CYCLES) @(posedge clock);
      check("boot_upper", up_on, b);
      check("boot_lower", lo_on - bl, 8 * BOOT_ON_CYC);
      reg_rd(REG_STATE, rd);
      check("state_boot", rd, 32'h40);
      check("boot_overlap", viol, 0);
      end_of_test;
   end
endmodule // sine_pwm_bldc_commutator_tb
